//--- logic/timing_controller.sv
// Purpose: One timing controller with five 16-bit counters and a scaler output
// Assumes: Timebase strobes come from the board, one clk_sys cycle wide
// Notes: Data port is byte-wide, low byte before high byte
`timescale 1ns/1ps
`default_nettype none
`include "timing_board_defs.svh"
module timing_controller #(
  parameter int N_CNT = 5
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host byte port
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic cmd_wr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Timebases
  input wire logic [4:0] tb_tick,
  input wire logic fast_tick,
  // Counter pins
  input wire logic [N_CNT-1:0] source_in,
  input wire logic [N_CNT-1:0] gate_in,
  output logic [N_CNT-1:0] count_out,
  output logic frequency_scaler_output
);
  typedef struct packed {
    timing_board_pkg::counter_type [N_CNT-1:0] c;
    logic [2:0] sel_reg;
    logic [2:0] sel_cnt;
    logic hi_byte;
    logic [7:0] lo_latch;
    logic [7:0] rd_r;
    logic [3:0] scale_div;
    logic [3:0] scale_cnt;
    logic scale_on;
    logic scale_out;
    logic [N_CNT-1:0] gate_d;
  } state_type;
  state_type s_r, s_nxt;
  // Source pick: timebase strobes or pin edge as configured
  function automatic logic src_edge(input logic [2:0] sel, input logic [4:0] tb, input logic fast,
                                    input logic pin, input logic pin_d, input logic gpin, input logic gpin_d);
    case (timing_board_pkg::src_sel_type'(sel))
      timing_board_pkg::SRC_REF: src_edge = tb[0];
      timing_board_pkg::SRC_REF_DIV10: src_edge = tb[1];
      timing_board_pkg::SRC_REF_DIV100: src_edge = tb[2];
      timing_board_pkg::SRC_REF_DIV1K: src_edge = tb[3];
      timing_board_pkg::SRC_REF_DIV10K: src_edge = tb[4];
      timing_board_pkg::SRC_PIN: src_edge = pin & ~pin_d;
      timing_board_pkg::SRC_FAST: src_edge = fast;
      default: src_edge = gpin & ~gpin_d;
    endcase
  endfunction : src_edge
  always_comb begin
    logic [15:0] word;
    logic en;
    logic edge_hit;
    timing_board_pkg::gate_mode_type gm;
    word = '0;
    en = 1'b0;
    edge_hit = 1'b0;
    gm = timing_board_pkg::GATE_NONE;
    s_nxt = s_r;
    s_nxt.gate_d = gate_in;
    for (int i = 0; i < N_CNT; i++) begin
      s_nxt.c[i].src_d = source_in[i];
      edge_hit = src_edge(s_r.c[i].mode[`MODE_SRC_LSB +: 3], tb_tick, fast_tick, source_in[i],
                          s_r.c[i].src_d, gate_in[i], s_r.gate_d[i]);
      gm = timing_board_pkg::gate_mode_type'(s_r.c[i].mode[`MODE_GATE_LSB +: 2]);
      // Gate is sampled as-is, not aligned to the timebase, so it may land one tick late
      case (gm)
        timing_board_pkg::GATE_HIGH: en = gate_in[i];
        timing_board_pkg::GATE_LOW: en = ~gate_in[i];
        timing_board_pkg::GATE_RISE: en = s_r.c[i].started;
        default: en = 1'b1;
      endcase
      if (gm == timing_board_pkg::GATE_RISE && gate_in[i] && !s_r.gate_d[i] && s_r.c[i].armed)
        s_nxt.c[i].started = 1'b1;
      if (s_r.c[i].armed && en && edge_hit) begin
        if (s_r.c[i].cnt == 16'h0001) begin
          s_nxt.c[i].cnt = s_r.c[i].mode[`MODE_RELOAD_BIT] ? s_r.c[i].load : 16'h0000;
          s_nxt.c[i].armed = s_r.c[i].mode[`MODE_RELOAD_BIT];
          s_nxt.c[i].out = s_r.c[i].mode[`MODE_TOGGLE_BIT] ? ~s_r.c[i].out : 1'b1;
        end else begin
          s_nxt.c[i].cnt = s_r.c[i].cnt - 16'h0001;
          if (!s_r.c[i].mode[`MODE_TOGGLE_BIT])
            s_nxt.c[i].out = 1'b0;
        end
      end
    end
    // Frequency scaler, independent of the counters
    if (s_r.scale_on && tb_tick[0]) begin
      if (s_r.scale_cnt == 4'h0) begin
        s_nxt.scale_cnt = s_r.scale_div;
        s_nxt.scale_out = ~s_r.scale_out;
      end else begin
        s_nxt.scale_cnt = s_r.scale_cnt - 4'h1;
      end
    end
    // Command byte: bits 7:5 opcode, bits 4:0 counter mask for arm/disarm/save, bits 2:0 counter index otherwise
    if (cmd_wr) begin
      s_nxt.hi_byte = 1'b0;
      case (wdata[7:5])
        `CMD_ARM: begin
          for (int i = 0; i < N_CNT; i++)
            if (wdata[i]) begin
              s_nxt.c[i].armed = 1'b1;
              s_nxt.c[i].started = 1'b0;
              s_nxt.c[i].cnt = s_r.c[i].load;
            end
        end
        `CMD_DISARM: begin
          for (int i = 0; i < N_CNT; i++)
            if (wdata[i])
              s_nxt.c[i].armed = 1'b0;
        end
        `CMD_SAVE: begin
          for (int i = 0; i < N_CNT; i++)
            if (wdata[i])
              s_nxt.c[i].hold = s_r.c[i].cnt;
        end
        default: begin
          s_nxt.sel_reg = wdata[7:5];
          s_nxt.sel_cnt = wdata[2:0];
        end
      endcase
    end
    // Byte-wide 16-bit access, low byte first
    if (data_wr || data_rd) begin
      s_nxt.hi_byte = ~s_r.hi_byte;
      if (data_wr && !s_r.hi_byte)
        s_nxt.lo_latch = wdata;
      if (data_wr && s_r.hi_byte) begin
        word = {wdata, s_r.lo_latch};
        for (int i = 0; i < N_CNT; i++)
          if (s_r.sel_cnt == 3'(i)) begin
            case (s_r.sel_reg)
              `CMD_SEL_MODE: s_nxt.c[i].mode = word[7:0];
              `CMD_SEL_LOAD: s_nxt.c[i].load = word;
              `CMD_SEL_HOLD: s_nxt.c[i].hold = word;
              default: ;
            endcase
          end
        if (s_r.sel_reg == `CMD_SEL_SCALER) begin
          s_nxt.scale_div = word[3:0];
          s_nxt.scale_on = word[4];
        end
      end
      if (data_rd) begin
        word = 16'h0000;
        for (int i = 0; i < N_CNT; i++)
          if (s_r.sel_cnt == 3'(i))
            word = (s_r.sel_reg == `CMD_SEL_LOAD) ? s_r.c[i].load :
                   (s_r.sel_reg == `CMD_SEL_MODE) ? {8'h00, s_r.c[i].mode} : s_r.c[i].hold;
        s_nxt.rd_r = s_r.hi_byte ? word[15:8] : word[7:0];
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign rdata = s_r.rd_r;
  assign frequency_scaler_output = s_r.scale_out;
  for (genvar g = 0; g < N_CNT; g++) begin : g_out
    assign count_out[g] = s_r.c[g].out;
  end
endmodule : timing_controller
`default_nettype wire

//--- logic/timing_board_defs.svh
// Purpose: Constants for the dual timing controller board
// Assumes: 20 MHz system clock
// Notes: Offsets are byte offsets from the switch-selected base
`ifndef TIMING_BOARD_DEFS_SVH
`define TIMING_BOARD_DEFS_SVH
`define CLK_SYS_HZ 20000000
`define REF_CLK_HZ 1000000
`define FAST_CLK_HZ 5000000
`define REF_DIV_CYCLES (`CLK_SYS_HZ / `REF_CLK_HZ)
`define FAST_DIV_CYCLES (`CLK_SYS_HZ / `FAST_CLK_HZ)
`define OFS_TC_A_DATA 3'h0
`define OFS_TC_A_CMD 3'h1
`define OFS_TC_B_DATA 3'h2
`define OFS_TC_B_CMD 3'h3
`define OFS_IRQ_CTRL 3'h4
`define OFS_IRQ_STAT 3'h5
`define CMD_SEL_MODE 3'h0
`define CMD_SEL_LOAD 3'h1
`define CMD_SEL_HOLD 3'h2
`define CMD_SEL_SCALER 3'h3
`define CMD_ARM 3'h4
`define CMD_DISARM 3'h5
`define CMD_SAVE 3'h6
`define MODE_SRC_LSB 0
`define MODE_GATE_LSB 3
`define MODE_RELOAD_BIT 5
`define MODE_TOGGLE_BIT 6
`endif

//--- logic/timing_board_pkg.sv
// Purpose: Types for the dual timing controller board
// Assumes: Constants live in timing_board_defs.svh
// Notes: None
package timing_board_pkg;
  typedef enum logic [2:0] {
    SRC_REF = 3'h0, SRC_REF_DIV10 = 3'h1, SRC_REF_DIV100 = 3'h2,
    SRC_REF_DIV1K = 3'h3, SRC_REF_DIV10K = 3'h4, SRC_PIN = 3'h5, SRC_FAST = 3'h6, SRC_GATE_PIN = 3'h7
  } src_sel_type;
  typedef enum logic [1:0] {
    GATE_NONE = 2'h0, GATE_HIGH = 2'h1, GATE_LOW = 2'h2, GATE_RISE = 2'h3
  } gate_mode_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } host_req_type;
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] load;
    logic [15:0] hold;
    logic [7:0] mode;
    logic armed;
    logic started;
    logic out;
    logic src_d;
  } counter_type;
endpackage : timing_board_pkg

//--- logic/dual_timing_controller_board.sv
// Purpose: Dual timing controller board behind a byte-wide host I/O port
// Assumes: Host strobes synchronous to clk_sys, one cycle each
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "timing_board_defs.svh"
module dual_timing_controller_board #(
  parameter int N_IRQ_LINES = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host I/O channel
  input wire timing_board_pkg::host_req_type host_req,
  input wire logic [7:0] base_addr_switch,
  output logic [7:0] host_rdata,
  output logic host_rdata_oe,
  // Counter pins, board numbering 1..10 at bits 0..9
  input wire logic [9:0] source_in,
  input wire logic [9:0] gate_in,
  output logic [9:0] count_out,
  output logic [1:0] frequency_scaler_output,
  // Interrupts
  input wire logic external_interrupt_one,
  input wire logic external_interrupt_two,
  input wire logic [2:0] irq_level_jumper,
  input wire logic [1:0] counter_irq_jumper,
  output logic [N_IRQ_LINES-1:0] host_irq
);
  typedef struct packed {
    logic [4:0] ref_cnt;
    logic [2:0] fast_cnt;
    logic [3:0][3:0] dec_cnt;
    logic [4:0] tb_tick;
    logic fast_tick;
    logic [1:0] irq_en;
    logic [1:0] irq_pol;
    logic [1:0] irq_flag;
    logic [1:0] irq_d;
    logic [2:0] rd_sel;
    logic rd_oe;
  } state_type;
  state_type s_r, s_nxt;
  logic match;
  logic [2:0] ofs;
  logic [1:0] irq_pins;
  logic [7:0] rdata_a, rdata_b;
  function automatic logic is_hit(input logic [7:0] a, input logic [7:0] base);
    is_hit = (a[7:3] == base[7:3]);
  endfunction : is_hit
  assign match = is_hit(host_req.addr, base_addr_switch) && (host_req.wr || host_req.rd);
  assign ofs = host_req.addr[2:0];
  assign irq_pins[0] = external_interrupt_one | (counter_irq_jumper[0] & count_out[1]);
  assign irq_pins[1] = external_interrupt_two | (counter_irq_jumper[1] & count_out[6]);
  always_comb begin
    logic [1:0] hit;
    hit = '0;
    s_nxt = s_r;
    s_nxt.tb_tick = '0;
    s_nxt.fast_tick = 1'b0;
    // 1 MHz reference strobe and four decades below it
    if (s_r.ref_cnt == 5'(`REF_DIV_CYCLES - 1)) begin
      s_nxt.ref_cnt = '0;
      s_nxt.tb_tick[0] = 1'b1;
      for (int k = 0; k < 4; k++) begin
        if (k == 0 || s_nxt.tb_tick[k]) begin
          if (s_r.dec_cnt[k] == 4'h9) begin
            s_nxt.dec_cnt[k] = 4'h0;
            s_nxt.tb_tick[k+1] = 1'b1;
          end else begin
            s_nxt.dec_cnt[k] = s_r.dec_cnt[k] + 4'h1;
          end
        end
      end
    end else begin
      s_nxt.ref_cnt = s_r.ref_cnt + 5'h01;
    end
    if (s_r.fast_cnt == 3'(`FAST_DIV_CYCLES - 1)) begin
      s_nxt.fast_cnt = '0;
      s_nxt.fast_tick = 1'b1;
    end else begin
      s_nxt.fast_cnt = s_r.fast_cnt + 3'h1;
    end
    // Edge detect with per-input polarity
    s_nxt.irq_d = irq_pins;
    for (int k = 0; k < 2; k++) begin
      hit[k] = s_r.irq_pol[k] ? (irq_pins[k] & ~s_r.irq_d[k]) : (~irq_pins[k] & s_r.irq_d[k]);
    end
    // Control byte: bits 1:0 enable, 3:2 polarity, 5:4 clear, 7:6 disable
    if (match && host_req.wr && ofs == `OFS_IRQ_CTRL) begin
      s_nxt.irq_pol = host_req.wdata[3:2];
      s_nxt.irq_en = (s_r.irq_en | host_req.wdata[1:0]) & ~host_req.wdata[7:6];
      s_nxt.irq_flag = s_r.irq_flag & ~host_req.wdata[5:4];
    end
    // Set beats clear in the same cycle
    s_nxt.irq_flag = s_nxt.irq_flag | (hit & s_nxt.irq_en);
    s_nxt.rd_oe = match && host_req.rd;
    s_nxt.rd_sel = ofs;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // Controller A holds board counters 1-5, B holds 6-10
  timing_controller #(.N_CNT(5)) u_tc_a (
    .clk_sys(clk_sys),
    .rst(rst),
    .data_wr(match && host_req.wr && ofs == `OFS_TC_A_DATA),
    .data_rd(match && host_req.rd && ofs == `OFS_TC_A_DATA),
    .cmd_wr(match && host_req.wr && ofs == `OFS_TC_A_CMD),
    .wdata(host_req.wdata),
    .rdata(rdata_a),
    .tb_tick(s_r.tb_tick),
    .fast_tick(s_r.fast_tick),
    .source_in(source_in[4:0]),
    .gate_in(gate_in[4:0]),
    .count_out(count_out[4:0]),
    .frequency_scaler_output(frequency_scaler_output[0])
  );
  timing_controller #(.N_CNT(5)) u_tc_b (
    .clk_sys(clk_sys),
    .rst(rst),
    .data_wr(match && host_req.wr && ofs == `OFS_TC_B_DATA),
    .data_rd(match && host_req.rd && ofs == `OFS_TC_B_DATA),
    .cmd_wr(match && host_req.wr && ofs == `OFS_TC_B_CMD),
    .wdata(host_req.wdata),
    .rdata(rdata_b),
    .tb_tick(s_r.tb_tick),
    .fast_tick(s_r.fast_tick),
    .source_in(source_in[9:5]),
    .gate_in(gate_in[9:5]),
    .count_out(count_out[9:5]),
    .frequency_scaler_output(frequency_scaler_output[1])
  );
  always_comb begin
    case (s_r.rd_sel)
      `OFS_TC_A_DATA: host_rdata = rdata_a;
      `OFS_TC_B_DATA: host_rdata = rdata_b;
      `OFS_IRQ_CTRL: host_rdata = {4'h0, s_r.irq_pol, s_r.irq_en};
      `OFS_IRQ_STAT: host_rdata = {4'h0, irq_pins, s_r.irq_flag};
      default: host_rdata = 8'h00;
    endcase
  end
  assign host_rdata_oe = s_r.rd_oe;
  // Single request routed to the jumpered line
  for (genvar g = 0; g < N_IRQ_LINES; g++) begin : g_irq
    assign host_irq[g] = (irq_level_jumper == 3'(g)) && (|s_r.irq_flag);
  end
endmodule : dual_timing_controller_board
`default_nettype wire

//--- tb/board_sva.sv
// Purpose: Port assertions for the timing board
// Assumes: Host strobes last one cycle
// Notes: Sees board ports only
`timescale 1ns/1ps
`default_nettype none
module board_sva #(
  parameter int N_IRQ_LINES = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host
  input wire timing_board_pkg::host_req_type host_req,
  input wire logic [7:0] base_addr_switch,
  input wire logic [7:0] host_rdata,
  input wire logic host_rdata_oe,
  // Pins
  input wire logic [9:0] count_out,
  input wire logic external_interrupt_one,
  input wire logic external_interrupt_two,
  input wire logic [2:0] irq_level_jumper,
  input wire logic [1:0] counter_irq_jumper,
  input wire logic [N_IRQ_LINES-1:0] host_irq
);
  wire logic hit = host_req.addr[7:3] == base_addr_switch[7:3];
  wire logic [1:0] ext = {external_interrupt_two, external_interrupt_one};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_rd;
    host_req.rd && hit;
  endsequence
  // Reads are excluded too, in case status reads have side effects
  sequence s_quiet;
    !host_req.wr && !host_req.rd && $stable({ext, count_out, irq_level_jumper, counter_irq_jumper});
  endsequence
  sequence s_clear;
    host_req.wr && hit && host_req.addr[2:0] == 3'h4 && host_req.wdata == 8'h30 && counter_irq_jumper == 2'h0;
  endsequence
  a_read_answer: assert property (s_rd |=> host_rdata_oe)
    else $error("accepted read got no answer");
  a_foreign_silent: assert property (!(host_req.rd && hit) |=> !host_rdata_oe)
    else $error("answer without accepted read");
  a_back_to_back: assert property (s_rd ##1 s_rd |-> host_rdata_oe ##1 host_rdata_oe)
    else $error("back to back reads not both answered");
  a_reserved_zero: assert property (s_rd ##0 host_req.addr[2:0] >= 3'h6 |=> host_rdata == 8'h00)
    else $error("reserved offset read not zero");
  a_irq_one_line: assert property ((host_irq & ~(N_IRQ_LINES'(1) << irq_level_jumper)) == '0)
    else $error("request on a line not selected");
  a_irq_steady: assert property (s_quiet [*6] |-> $stable(host_irq))
    else $error("request changed without cause");
  a_irq_clear: assert property ($stable(ext) [*5] ##0 s_clear |-> ##[1:3] host_irq == '0)
    else $error("clear did not drop request");
  a_reset_quiet: assert property (disable iff (1'b0) rst |-> !host_rdata_oe && count_out == '0 && host_irq == '0)
    else $error("outputs active in reset");
endmodule : board_sva
bind dual_timing_controller_board board_sva #(.N_IRQ_LINES(N_IRQ_LINES)) i_sva (
  .clk_sys(clk_sys), .rst(rst), .host_req(host_req), .base_addr_switch(base_addr_switch),
  .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe), .count_out(count_out),
  .external_interrupt_one(external_interrupt_one), .external_interrupt_two(external_interrupt_two),
  .irq_level_jumper(irq_level_jumper), .counter_irq_jumper(counter_irq_jumper), .host_irq(host_irq));
`default_nettype wire

//--- tb/host_bus_model.sv
// Purpose: Host I/O channel model issuing byte transfers
// Assumes: Board answers a read one cycle after the strobe
// Notes: Released lines show the inverse address and the inverse of the low data byte
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // Clock
  input wire logic clk_sys,
  // Channel
  output var timing_board_pkg::host_req_type host_req,
  input wire logic [7:0] host_rdata,
  input wire logic host_rdata_oe
);
  initial host_req = '0;
  // One or two bytes on consecutive cycles, low byte first
  task automatic acc(input logic [7:0] a, input logic w, input logic [15:0] d, input int n,
                     output logic [15:0] q, output logic [1:0] ok);
    @(posedge clk_sys);
    host_req <= '{a, d[7:0], w, !w};
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      if (i == n - 1)
        host_req <= '{~a, ~d[7:0], 1'b0, 1'b0};
      else
        host_req <= '{a, d[15:8], w, !w};
      #1;
      ok[i] = host_rdata_oe;
      q[8*i +: 8] = host_rdata;
    end
  endtask : acc
endmodule : host_bus_model
`default_nettype wire

//--- tb/tb.sv
// Purpose: Self-checking bench for the dual timing controller board
// Assumes: Host model drives byte transfers from clock edges
// Notes: Base switch fixed at A0
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [7:0] ofs;
    logic [7:0] cmd;
    logic [15:0] val;
  } row_type;
  localparam logic [7:0] BASE = 8'hA0;
  logic clk_sys = 1'b0;
  logic rst = 1'b0;
  logic [9:0] gate = 10'h000;
  timing_board_pkg::host_req_type host_req;
  logic [7:0] host_rdata;
  logic host_rdata_oe;
  logic [9:0] count_out;
  logic [1:0] fso;
  logic [1:0] ext = 2'h0;
  logic [2:0] lvl = 3'h5;
  logic [1:0] cirq = 2'h0;
  logic [7:0] host_irq;
  logic [15:0] q;
  logic [1:0] ok;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int per;
  row_type rows [4] = '{'{8'h00, 8'h20, 16'h1234}, '{8'h02, 8'h20, 16'h0001},
                        '{8'h00, 8'h24, 16'h8000}, '{8'h02, 8'h24, 16'hFFFF}};
  always #25 clk_sys = ~clk_sys;
  host_bus_model i_host (.clk_sys(clk_sys), .host_req(host_req), .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe));
  dual_timing_controller_board i_dut (.clk_sys(clk_sys), .rst(rst), .host_req(host_req),
    .base_addr_switch(BASE), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
    .source_in(10'h000), .gate_in(gate), .count_out(count_out), .frequency_scaler_output(fso),
    .external_interrupt_one(ext[0]), .external_interrupt_two(ext[1]), .irq_level_jumper(lvl),
    .counter_irq_jumper(cirq), .host_irq(host_irq));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] o, input logic [15:0] d, input int n);
    i_host.acc(BASE + o, 1'b1, d, n, q, ok);
  endtask : wr
  task automatic rd(input logic [7:0] o, input int n);
    i_host.acc(BASE + o, 1'b0, 16'h0000, n, q, ok);
  endtask : rd
  task automatic settle(input logic [7:0] e);
    for (int i = 0; i < 20 && host_irq !== e; i++)
      @(negedge clk_sys);
    chk(host_irq, e);
  endtask : settle
  // Cycles between the first two rising edges of counter 2 output
  task automatic period(output int p);
    int t0;
    logic prev;
    t0 = -1;
    p = 0;
    prev = 1'b1;
    repeat (400) begin
      @(negedge clk_sys);
      if (count_out[1] && !prev && t0 >= 0 && p == 0)
        p = cyc - t0;
      if (count_out[1] && !prev && t0 < 0)
        t0 = cyc;
      prev = count_out[1];
    end
  endtask : period
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    // A real edge on the async reset, so the board state is known before the first clock
    rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    chk({host_rdata_oe, fso, count_out, host_irq}, 24'h000000);
    rst <= 1'b0;
    i_host.acc(8'h40, 1'b0, 16'h0000, 1, q, ok);
    chk(ok[0], 1'b0);
    for (int o = 6; o < 8; o++) begin
      wr(o[7:0], 16'h00FF, 1);
      rd(o[7:0], 1);
      chk({ok[0], q[7:0]}, 9'h100);
    end
    foreach (rows[i]) begin
      wr(rows[i].ofs + 8'h01, rows[i].cmd, 1);
      wr(rows[i].ofs, rows[i].val, 2);
      wr(rows[i].ofs + 8'h01, rows[i].cmd, 1);
      rd(rows[i].ofs, 2);
      chk({ok, q}, {2'b11, rows[i].val});
    end
    wr(8'h01, 16'h0020, 1);
    rd(8'h00, 2);
    chk(q, 16'h1234);
    wr(8'h01, 16'h0060, 1);
    wr(8'h00, 16'h0011, 2);
    for (int i = 0; i < 400 && fso !== 2'b01; i++)
      @(negedge clk_sys);
    chk(fso, 2'b01);
    @(posedge clk_sys) cirq <= 2'b01;
    wr(8'h04, 16'h0005, 1);
    // Fast source first, then the 1 MHz timebase; load 3 with reload
    for (int s = 0; s < 2; s++) begin
      wr(8'h01, 16'h0001, 1);
      wr(8'h00, s ? 16'h0020 : 16'h0026, 2);
      wr(8'h01, 16'h0021, 1);
      wr(8'h00, 16'h0003, 2);
      wr(8'h01, 16'h0082, 1);
      period(per);
      chk(24'(per), s ? 24'h00003C : 24'h00000C);
    end
    chk(host_irq, 8'h20);
    @(posedge clk_sys) cirq <= 2'b00;
    wr(8'h01, 16'h00A2, 1);
    wr(8'h04, 16'h0030, 1);
    settle(8'h00);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys) begin
        ext[k % 2] <= k > 1;
        lvl <= k[2:0] + 3'h1;
      end
      wr(8'h04, (k < 2 ? 16'h0005 : 16'h0001) << (k % 2), 1);
      repeat (10) @(posedge clk_sys);
      // Polarity change may look like an edge, so start from a cleared flag
      // Every control write also rewrites polarity, so the clear carries it along
      wr(8'h04, (k < 2 ? 16'h0014 : 16'h0010) << (k % 2), 1);
      settle(8'h00);
      @(posedge clk_sys) ext[k % 2] <= k < 2;
      settle(8'h01 << (k + 1));
      rd(8'h05, 1);
      chk(q[1:0], 2'b01 << (k % 2));
      wr(8'h04, (k < 2 ? 16'h0014 : 16'h0010) << (k % 2), 1);
      settle(8'h00);
      wr(8'h04, 16'h0040 << (k % 2), 1);
      @(posedge clk_sys) ext[k % 2] <= k > 1;
      @(posedge clk_sys) ext[k % 2] <= k < 2;
      repeat (20) @(posedge clk_sys);
      chk(host_irq, 8'h00);
    end
    // Counter 3: fast source, counts only while its gate is high, one shot, load 5
    wr(8'h01, 16'h0002, 1);
    wr(8'h00, 16'h000E, 2);
    wr(8'h01, 16'h0022, 1);
    wr(8'h00, 16'h0005, 2);
    wr(8'h01, 16'h0084, 1);
    repeat (40) @(posedge clk_sys);
    wr(8'h01, 16'h00C4, 1);
    wr(8'h01, 16'h0042, 1);
    rd(8'h00, 2);
    chk({ok, q}, 18'h30005);
    chk(count_out[2], 1'b0);
    @(posedge clk_sys) gate[2] <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk(count_out[2], 1'b1);
    @(posedge clk_sys) rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({host_rdata_oe, fso, count_out, host_irq}, 24'h000000);
    rst <= 1'b0;
    // Selection and byte order start over after reset: mode of counter 1, low byte first
    rd(8'h00, 2);
    chk({ok, q}, 18'h30000);
    chk({fso, count_out, host_irq}, 24'h000000);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
